// file: bench/sose_sync_source.sv
// Purpose: Video sync source making rising-edge pulses on the four sync input pins
// Assumes: Pulse requests arrive from the bench as one-cycle masks
// Notes: Pins rest low between pulses as a driven sync line does; slow pulses are held longer
`timescale 1ns/1ps
module sose_sync_source (
  input wire logic clock,
  input wire logic [3:0] fire,
  input wire logic slow,
  output logic [3:0] pins
);
  logic [2:0] hold [4];
  initial begin
    pins = 4'h0;
    for (int i = 0; i < 4; i++) hold[i] = 3'h0;
  end
  always @(posedge clock) begin
    for (int i = 0; i < 4; i++) begin
      if (fire[i]) begin
        pins[i] <= 1'b1;
        hold[i] <= slow ? 3'h6 : 3'h2;
      end else if (hold[i] != 3'h0) hold[i] <= hold[i] - 3'h1;
      else pins[i] <= 1'b0;
    end
  end
endmodule

// file: bench/sose_top_asserts.sv
// Purpose: Port-level checks for the sync output select and edge sense block
// Assumes: One clock, reset_n asynchronous active low, aw and w offered together
// Notes: Port-mode checks skip the first edge after reset, which still sees reset-time inputs
`timescale 1ns/1ps
module sose_top_asserts import sose_pkg::*; (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [sose_pkg::ADDR_WIDTH-1:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [31:0] wdata,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [sose_pkg::ADDR_WIDTH-1:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic frt_compare_b_out_enable,
  input wire logic [3:0] timer_one_output_select_field,
  input wire logic [3:0] timer_x_output_select_field,
  input wire logic vertical_port_out,
  input wire logic vertical_sync_out_pin,
  input wire logic vertical_port_mode,
  input wire logic horizontal_port_mode,
  input wire logic clamp_port_mode,
  input wire logic [2:0] twowire_mode,
  input wire logic pwm_clock_enable,
  input wire logic pwm_clock_select,
  input wire logic eight_bit_clock_sel_high,
  input wire logic eight_bit_clock_sel_low
);
  logic [7:0] ctl_byte;
  wire ctl_take = awvalid && awready && wvalid && wready && awaddr == CONTROL_OFFSET;
  // Keeps the written byte, since wdata may move on before the routed copies settle
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) ctl_byte <= 8'h00;
    else if (ctl_take) ctl_byte <= wdata[7:0];
  end
  default clocking dc @(posedge clock); endclocking
  default disable iff (!reset_n);
  sequence ctl_settled;
    // Taken, then stored one edge later, then copied out one edge after that
    ctl_take ##3 1'b1;
  endsequence
  sequence edge_read;
    arvalid && arready && araddr == EDGE_OFFSET ##2 rvalid;
  endsequence
  AST_CTRL_RESET:
    assert property ($rose(reset_n) |-> ctl_byte == 8'h00 && twowire_mode == 3'h0 && !pwm_clock_enable)
      else $error("control copies not clear after reset");
  AST_PORT_LEVEL:
    assert property ($past(reset_n) && vertical_port_mode |-> vertical_sync_out_pin == $past(vertical_port_out))
      else $error("port-mode vertical pin does not follow its port level");
  AST_VERT_PORT:
    assert property ($past(reset_n) && $past(frt_compare_b_out_enable) |-> !vertical_port_mode)
      else $error("vertical pin left as port with compare output enabled");
  AST_HORIZ_PORT:
    assert property ($past(reset_n) && |$past(timer_one_output_select_field) |-> !horizontal_port_mode)
      else $error("horizontal pin left as port with timer one output selected");
  AST_CLAMP_PORT:
    assert property ($past(reset_n) && |$past(timer_x_output_select_field) |-> !clamp_port_mode)
      else $error("clamp pin left as port with timer x output selected");
  AST_TWOWIRE:
    assert property (ctl_settled |-> twowire_mode == ctl_byte[7:5])
      else $error("two-wire mode copy wrong after control write");
  AST_PWM:
    assert property (ctl_settled |-> {pwm_clock_enable, pwm_clock_select} == ctl_byte[3:2])
      else $error("pwm clock bits wrong after control write");
  AST_EIGHT:
    assert property (ctl_settled |-> {eight_bit_clock_sel_high, eight_bit_clock_sel_low} == ctl_byte[1:0])
      else $error("eight-bit clock bits wrong after control write");
  AST_EDGE_LOW:
    assert property (edge_read |-> rdata[3:0] == EDGE_LOW_ONES && rdata[31:8] == 24'h000000)
      else $error("edge register low or upper bits wrong");
endmodule
bind sose_top sose_top_asserts sose_top_asserts_inst (.*);

// file: bench/test_sync_output_select_edge_sense.sv
// Purpose: Self-checking bench for registers, pin selection and edge flags
// Assumes: 40 MHz clock, AXI4-Lite master offering aw and w together
// Notes: Read data and write responses are queued and checked by a separate watcher
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_sync_output_select_edge_sense import sose_pkg::*; ;
  logic clock, reset_n, awvalid, wvalid, bready, arvalid, rready, standby, slow;
  logic awready, wready, bvalid, arready, rvalid, vertical_sync_out_pin, horizontal_sync_out_pin, clamp_out_pin;
  logic vertical_port_mode, horizontal_port_mode, clamp_port_mode, pwm_clock_enable, pwm_clock_select;
  logic eight_bit_clock_sel_high, eight_bit_clock_sel_low;
  logic [1:0] bresp, rresp;
  logic [2:0] twowire_mode;
  logic [3:0] awaddr, araddr, wstrb, fire, pins;
  logic [31:0] wdata, rdata, seed;
  logic [18:0] src;
  logic [33:0] exp_r[$];
  logic [1:0] exp_b[$];
  int n_fail = 0, check_count = 0, cycles = 0;
  wire [5:0] pin_now = {vertical_sync_out_pin, horizontal_sync_out_pin, clamp_out_pin, vertical_port_mode,
    horizontal_port_mode, clamp_port_mode};
  wire [6:0] ctl_now = {twowire_mode, pwm_clock_enable, pwm_clock_select, eight_bit_clock_sel_high,
    eight_bit_clock_sel_low};
  sose_top sose_top_inst (.*, .vertical_sync_in_pin(pins[3]), .horizontal_sync_in_pin(pins[2]),
    .composite_sync_in_pin(pins[1]), .spare_sync_in_pin(pins[0]), .frt_compare_b_out_enable(src[18]),
    .timer_one_output_select_field(src[17:14]), .timer_x_output_select_field(src[13:10]),
    .frt_compare_b_output(src[9]), .timer_one_output(src[8]), .timer_x_output(src[7]),
    .internal_vertical_signal(src[6]), .internal_horizontal_in_signal(src[5]), .clamp_wave_one(src[4]),
    .clamp_wave_two(src[3]), .vertical_port_out(src[2]), .horizontal_port_out(src[1]), .clamp_port_out(src[0]));
  sose_sync_source sose_sync_source_inst (.clock(clock), .fire(fire), .slow(slow), .pins(pins));
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [5:0] pin_exp(input logic se, input logic [7:0] m, input logic [18:0] s);
    logic v, h, c;
    v = se ? s[6] ^ m[0] : (s[18] ? s[9] : s[2]);
    h = se ? ((m[7] ^ m[6]) ? s[4] : s[5]) ^ m[0] : ((|s[17:14]) ? s[8] : s[1]);
    c = se ? (m[5] ? s[3] : s[4]) : ((|s[13:10]) ? s[7] : s[0]);
    return {v, h, c, !se && !s[18], !se && s[17:14] == 4'h0, !se && s[13:10] == 4'h0};
  endfunction
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // One transfer at a time; handshakes are judged at the falling edge so no edge race decides them
  task automatic io(input bit is_wr, input logic [3:0] a, input logic [7:0] d, input logic [1:0] r = RESP_OKAY);
    bit ha, hw, hr, done;
    @(posedge clock);
    if (is_wr) begin
      exp_b.push_back(r);
      awaddr <= a;
      wdata <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
    end else begin
      exp_r.push_back({r, 24'h000000, d});
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
    end
    done = 1'b0;
    while (!done) begin
      @(negedge clock);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hr = arvalid && arready;
      done = (bvalid && bready) || (rvalid && rready);
      @(posedge clock);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      if (hr) arvalid <= 1'b0;
      if (done) begin
        bready <= 1'b0;
        rready <= 1'b0;
      end
    end
  endtask
  task automatic pulse(input logic [3:0] m, input logic s);
    fire <= m;
    slow <= s;
    @(posedge clock);
    fire <= 4'h0;
    repeat (10) @(posedge clock);
  endtask
  always @(negedge clock) begin
    logic [33:0] e;
    if (bvalid && bready) begin
      e[1:0] = exp_b.pop_front();
      `CHK(bresp, e[1:0])
    end
    if (rvalid && rready) begin
      e = exp_r.pop_front();
      `CHK({rresp, rdata}, e)
    end
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles > 6000) begin
      n_fail++;
      print_verdict();
    end
  end
  initial begin
    logic [7:0] d;
    logic [5:0] e;
    {awvalid, wvalid, bready, arvalid, rready, standby, slow} = 7'h00;
    {awaddr, araddr, wstrb, fire} = 16'h00F0;
    wdata = 32'h0;
    src = 19'h0;
    seed = 32'h98F9;
    e = 6'h00;
    reset_n = 1'b0;
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
    @(negedge clock);
    `CHK(ctl_now, 7'h00)
    `CHK(pin_now, 6'h07)
    io(1'b0, CONTROL_OFFSET, CONTROL_RESET);
    io(1'b0, EDGE_OFFSET, EDGE_RESET);
    $display("reset test done");
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      d = (i < 2) ? {8{i[0]}} : seed[7:0];
      io(1'b1, CONTROL_OFFSET, d);
      @(negedge clock);
      `CHK(ctl_now, {d[7:5], d[3:0]})
      io(1'b0, CONTROL_OFFSET, d);
    end
    $display("control test done");
    for (int k = 0; k < 32; k++) begin
      io(1'b1, CONTROL_OFFSET, {3'h0, k[0], 4'h0});
      io(1'b1, MODE_OFFSET, {k[2:1], k[3], 4'h0, k[4]});
      io(1'b0, MODE_OFFSET, {k[2:1], k[3], 4'h0, k[4]});
      for (int c = 0; c < 9; c++) begin
        @(posedge clock);
        seed = xs(seed);
        src <= seed[18:0] & {1'b1, {4{seed[25]}}, {4{seed[26]}}, 10'h3FF};
        @(negedge clock);
        if (c > 0) `CHK(pin_now, e)
        e = pin_exp(k[0], {k[2:1], k[3], 4'h0, k[4]}, src);
      end
    end
    $display("pin select test done");
    @(posedge clock);
    for (int i = 0; i < 4; i++) begin
      d = 8'h0F | (8'h10 << i);
      pulse(4'h1 << i, i[0]);
      io(1'b1, EDGE_OFFSET, 8'h0F);
      io(1'b0, EDGE_OFFSET, d);
      io(1'b1, EDGE_OFFSET, 8'hFF);
      io(1'b1, EDGE_OFFSET, 8'h0F);
      io(1'b0, EDGE_OFFSET, d);
      io(1'b1, EDGE_OFFSET, 8'h0F);
      io(1'b0, EDGE_OFFSET, EDGE_RESET);
    end
    $display("edge flag test done");
    pulse(4'hF, 1'b0);
    io(1'b0, EDGE_OFFSET, 8'hFF);
    standby <= 1'b1;
    @(posedge clock);
    standby <= 1'b0;
    io(1'b0, EDGE_OFFSET, EDGE_RESET);
    pulse(4'h9, 1'b1);
    io(1'b1, STANDBY_OFFSET, 8'h01);
    io(1'b0, EDGE_OFFSET, EDGE_RESET);
    io(1'b0, STANDBY_OFFSET, 8'h00);
    io(1'b1, 4'h2, 8'h55, RESP_SLVERR);
    io(1'b0, 4'h6, 8'h00, RESP_SLVERR);
    io(1'b0, CONTROL_OFFSET, 8'h10);
    $display("standby and unmapped test done");
    print_verdict();
  end
endmodule

// file: verilog/sose_axil_slave.sv
// Purpose: AXI4-Lite slave front end producing single-cycle register strobes
// Assumes: One write and one read outstanding at most
// Notes: Write strobe fires when both address and data are held
`timescale 1ns/1ps
module sose_axil_slave (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [sose_pkg::ADDR_WIDTH-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [sose_pkg::ADDR_WIDTH-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic write_strobe,
  output logic [sose_pkg::ADDR_WIDTH-1:0] write_addr,
  output logic [7:0] write_data,
  output logic write_lane0,
  output logic read_strobe,
  output logic [sose_pkg::ADDR_WIDTH-1:0] read_addr,
  input wire logic [7:0] read_value,
  input wire logic read_hit,
  input wire logic write_hit
);
  import sose_pkg::*;
  logic have_addr;
  logic have_data;
  logic read_pending;
  logic [7:0] data_hold;
  logic lane_hold;
  wire take_aw = awvalid & awready;
  wire take_w = wvalid & wready;
  wire take_ar = arvalid & arready;
  wire fire_write = have_addr & have_data & ~bvalid;

  // Readies are flops that track a free slot, so no port of the top is combinational
  assign write_strobe = fire_write;
  assign write_data = data_hold;
  assign write_lane0 = lane_hold;
  assign read_strobe = read_pending;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      have_addr <= 1'b0;
      have_data <= 1'b0;
      write_addr <= '0;
      awready <= 1'b1;
      wready <= 1'b1;
      data_hold <= 8'h00;
      lane_hold <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      if (take_aw) begin
        have_addr <= 1'b1;
        awready <= 1'b0;
        write_addr <= awaddr;
      end
      if (take_w) begin
        have_data <= 1'b1;
        wready <= 1'b0;
        data_hold <= wdata[7:0];
        lane_hold <= wstrb[0];
      end
      if (fire_write) begin
        have_addr <= 1'b0;
        have_data <= 1'b0;
        bvalid <= 1'b1;
        bresp <= write_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // Read takes one cycle for decode, answer the next
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      read_pending <= 1'b0;
      read_addr <= '0;
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else begin
      if (take_ar) begin
        read_pending <= 1'b1;
        arready <= 1'b0;
        read_addr <= araddr;
      end
      if (read_pending) begin
        read_pending <= 1'b0;
        rvalid <= 1'b1;
        rdata <= {24'h00_0000, read_value};
        rresp <= read_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end
endmodule

// file: verilog/sose_edge_detect.sv
// Purpose: Three-stage sampler and rising edge pulse for one sync input pin
// Assumes: Pin is asynchronous to clock
// Notes: Change counts once second and third stages agree
`timescale 1ns/1ps
module sose_edge_detect (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic pin,
  output logic rise
);
  logic stage1;
  logic stage2;
  logic stage3;
  logic settled;
  logic next_settled;

  // Rising edge is a settled 0 followed by a settled 1
  assign next_settled = (stage2 == stage3) ? stage3 : settled;
  assign rise = next_settled & ~settled; // R16

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
      settled <= 1'b0;
    end else begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
      settled <= next_settled;
    end
  end
endmodule

// file: verilog/sose_pkg.sv
// Purpose: Shared constants for the sync output select and edge sense block
// Assumes: AXI4-Lite register access, 32-bit data, 40 MHz clock
// Notes: Offsets are byte addresses of aligned words
package sose_pkg;
  localparam int ADDR_WIDTH = 4;
  localparam logic [3:0] CONTROL_OFFSET = 4'h0;
  localparam logic [3:0] EDGE_OFFSET = 4'h4;
  localparam logic [3:0] MODE_OFFSET = 4'h8;
  localparam logic [3:0] STANDBY_OFFSET = 4'hC;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] EDGE_RESET = 8'h0F;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [3:0] EDGE_LOW_ONES = 4'hF;
  // Control register fields
  localparam int TWOWIRE_MSB = 7;
  localparam int TWOWIRE_LSB = 5;
  localparam int SYNC_ENABLE_BIT = 4;
  localparam int PWM_ENABLE_BIT = 3;
  localparam int PWM_SELECT_BIT = 2;
  localparam int EIGHT_HIGH_BIT = 1;
  localparam int EIGHT_LOW_BIT = 0;
  // Mode register fields
  localparam int MODE_HIGH_BIT = 7;
  localparam int MODE_LOW_BIT = 6;
  localparam int CLAMP_MODE_BIT = 5;
  localparam int INVERT_BIT = 0;
  // Edge flags sit in bits 7..4 in the order vertical, horizontal, composite, spare
  localparam int EDGE_LSB = 4;
  localparam int EDGE_COUNT = 4;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// file: verilog/sose_top.sv
// Purpose: Serial/timer control, sync pin output selection and sync input edge flags
// Assumes: Single 40 MHz clock; timer, clamp and internal sync signals come from other units
// Notes: Pin selection is registered, so outputs lag their sources by one clock
`timescale 1ns/1ps
// Functional notes
// R1: Control register resets to zero; all eight bits read and write.
// R2: Sync enable 0 keeps port/timer roles; 1 selects sync and clamp outputs.
// R3: Vertical pin: port, compare B output, or internal vertical when enabled.
// R4: Horizontal pin: port or timer one; enabled, internal horizontal or clamp one by mode.
// R5: Clamp pin: port or timer X; enabled, clamp one or two by clamp mode.
// R6: Top three control bits go to the two-wire bus unit only.
// R7: PWM clock enable and select bits go to the PWM timers.
// R8: Two low clock select bits go to the eight-bit timers.
// R9: Edge register becomes 0x0F on reset or standby; low bits read one.
// R10: Vertical input rising edge sets its flag; cleared by read-one then write-zero.
// R11: Horizontal input rising edge sets its flag; cleared by read-one then write-zero.
// R12: Composite input rising edge sets its flag; cleared by read-one then write-zero.
// R13: Spare input rising edge sets its flag; cleared by read-one then write-zero.
// R14: Writing one to an edge flag leaves it unchanged.
// R15: Invert bit inverts vertical and horizontal sync outputs.
// R16: Inputs sampled on clock; hardware set beats a clearing write.
module sose_top (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [sose_pkg::ADDR_WIDTH-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [sose_pkg::ADDR_WIDTH-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic standby,
  input wire logic vertical_sync_in_pin,
  input wire logic horizontal_sync_in_pin,
  input wire logic composite_sync_in_pin,
  input wire logic spare_sync_in_pin,
  input wire logic frt_compare_b_out_enable,
  input wire logic [3:0] timer_one_output_select_field,
  input wire logic [3:0] timer_x_output_select_field,
  input wire logic frt_compare_b_output,
  input wire logic timer_one_output,
  input wire logic timer_x_output,
  input wire logic internal_vertical_signal,
  input wire logic internal_horizontal_in_signal,
  input wire logic clamp_wave_one,
  input wire logic clamp_wave_two,
  input wire logic vertical_port_out,
  input wire logic horizontal_port_out,
  input wire logic clamp_port_out,
  output logic vertical_sync_out_pin,
  output logic horizontal_sync_out_pin,
  output logic clamp_out_pin,
  output logic vertical_port_mode,
  output logic horizontal_port_mode,
  output logic clamp_port_mode,
  output logic [2:0] twowire_mode,
  output logic pwm_clock_enable,
  output logic pwm_clock_select,
  output logic eight_bit_clock_sel_high,
  output logic eight_bit_clock_sel_low
);
  import sose_pkg::*;

  logic [7:0] serial_timer_control;
  logic [7:0] sync_mode;
  logic [EDGE_COUNT-1:0] edge_flags;
  logic [EDGE_COUNT-1:0] read_seen;
  logic [EDGE_COUNT-1:0] rise;
  logic standby_seen;
  logic write_strobe;
  logic [ADDR_WIDTH-1:0] write_addr;
  logic [7:0] write_data;
  logic write_lane0;
  logic read_strobe;
  logic [ADDR_WIDTH-1:0] read_addr;
  logic [7:0] read_value;
  logic read_hit;
  logic write_hit;

  sose_axil_slave sose_axil_slave_inst (
    .clock(clock),
    .reset_n(reset_n),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .write_strobe(write_strobe),
    .write_addr(write_addr),
    .write_data(write_data),
    .write_lane0(write_lane0),
    .read_strobe(read_strobe),
    .read_addr(read_addr),
    .read_value(read_value),
    .read_hit(read_hit),
    .write_hit(write_hit)
  );

  // Pins ordered so index 3 is vertical, matching flag bit 7
  wire [EDGE_COUNT-1:0] sync_pins = {vertical_sync_in_pin, horizontal_sync_in_pin,
                                     composite_sync_in_pin, spare_sync_in_pin};

  genvar i;
  generate
    for (i = 0; i < EDGE_COUNT; i++) begin : g_edge
      sose_edge_detect sose_edge_detect_inst (
        .clock(clock),
        .reset_n(reset_n),
        .pin(sync_pins[i]),
        .rise(rise[i])
      );
    end
  endgenerate

  // Address decode
  wire write_control = write_strobe & write_lane0 & (write_addr == CONTROL_OFFSET);
  wire write_edge = write_strobe & write_lane0 & (write_addr == EDGE_OFFSET);
  wire write_mode = write_strobe & write_lane0 & (write_addr == MODE_OFFSET);
  wire write_standby = write_strobe & write_lane0 & (write_addr == STANDBY_OFFSET);
  assign write_hit = (write_addr == CONTROL_OFFSET) | (write_addr == EDGE_OFFSET) |
                     (write_addr == MODE_OFFSET) | (write_addr == STANDBY_OFFSET);
  assign read_hit = (read_addr == CONTROL_OFFSET) | (read_addr == EDGE_OFFSET) |
                    (read_addr == MODE_OFFSET) | (read_addr == STANDBY_OFFSET);
  wire edge_read = read_strobe & (read_addr == EDGE_OFFSET);
  wire [7:0] edge_value = {edge_flags, EDGE_LOW_ONES}; // R9
  assign read_value = (read_addr == CONTROL_OFFSET) ? serial_timer_control :
                      (read_addr == EDGE_OFFSET) ? edge_value :
                      (read_addr == MODE_OFFSET) ? sync_mode :
                      (read_addr == STANDBY_OFFSET) ? {7'h00, standby} : 8'h00;

  // Standby entry is the rising edge of the standby level
  wire standby_entry = standby & ~standby_seen;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      serial_timer_control <= CONTROL_RESET; // R1
      sync_mode <= MODE_RESET;
      standby_seen <= 1'b0;
    end else begin
      standby_seen <= standby;
      if (write_control) begin
        serial_timer_control <= write_data; // R1
      end
      if (write_mode) begin
        sync_mode <= write_data;
      end
    end
  end

  // Flag clear needs a prior read that saw the flag at one
  wire [EDGE_COUNT-1:0] write_zero = ~write_data[EDGE_LSB +: EDGE_COUNT];
  wire [EDGE_COUNT-1:0] clear_flag = {EDGE_COUNT{write_edge}} & write_zero & read_seen; // R10 R11 R12 R13
  // Ones written are ignored; set wins over clear
  wire [EDGE_COUNT-1:0] next_edge_flags = (edge_flags & ~clear_flag) | rise; // R14 R16
  wire [EDGE_COUNT-1:0] next_read_seen = write_edge ? {EDGE_COUNT{1'b0}} :
                                         edge_read ? (read_seen | edge_flags) : read_seen;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      edge_flags <= EDGE_RESET[7:4]; // R9
      read_seen <= '0;
    end else if (standby_entry || write_standby) begin
      edge_flags <= EDGE_RESET[7:4]; // R9
      read_seen <= '0;
    end else begin
      edge_flags <= next_edge_flags; // R10 R11 R12 R13
      read_seen <= next_read_seen & next_edge_flags;
    end
  end

  // Output selection
  wire sync_enable = serial_timer_control[SYNC_ENABLE_BIT]; // R2
  wire mode_high = sync_mode[MODE_HIGH_BIT];
  wire mode_low = sync_mode[MODE_LOW_BIT];
  wire clamp_mode = sync_mode[CLAMP_MODE_BIT];
  wire invert = sync_mode[INVERT_BIT];
  wire timer_one_on = |timer_one_output_select_field;
  wire timer_x_on = |timer_x_output_select_field;
  wire horizontal_out_signal = (mode_high ^ mode_low) ? clamp_wave_one
                                                      : internal_horizontal_in_signal; // R4
  wire next_vertical = sync_enable ? (internal_vertical_signal ^ invert) : // R3 R15
                       frt_compare_b_out_enable ? frt_compare_b_output : vertical_port_out;
  wire next_horizontal = sync_enable ? (horizontal_out_signal ^ invert) : // R4 R15
                         timer_one_on ? timer_one_output : horizontal_port_out;
  wire next_clamp = sync_enable ? (clamp_mode ? clamp_wave_two : clamp_wave_one) : // R5
                    timer_x_on ? timer_x_output : clamp_port_out;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      vertical_sync_out_pin <= 1'b0;
      horizontal_sync_out_pin <= 1'b0;
      clamp_out_pin <= 1'b0;
      vertical_port_mode <= 1'b1;
      horizontal_port_mode <= 1'b1;
      clamp_port_mode <= 1'b1;
    end else begin
      vertical_sync_out_pin <= next_vertical;
      horizontal_sync_out_pin <= next_horizontal;
      clamp_out_pin <= next_clamp;
      vertical_port_mode <= ~sync_enable & ~frt_compare_b_out_enable; // R2 R3
      horizontal_port_mode <= ~sync_enable & ~timer_one_on; // R2 R4
      clamp_port_mode <= ~sync_enable & ~timer_x_on; // R2 R5
    end
  end

  // Routed fields, registered so outputs come from flip-flops
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      twowire_mode <= 3'h0;
      pwm_clock_enable <= 1'b0;
      pwm_clock_select <= 1'b0;
      eight_bit_clock_sel_high <= 1'b0;
      eight_bit_clock_sel_low <= 1'b0;
    end else begin
      twowire_mode <= serial_timer_control[TWOWIRE_MSB:TWOWIRE_LSB]; // R6
      pwm_clock_enable <= serial_timer_control[PWM_ENABLE_BIT]; // R7
      pwm_clock_select <= serial_timer_control[PWM_SELECT_BIT]; // R7
      eight_bit_clock_sel_high <= serial_timer_control[EIGHT_HIGH_BIT]; // R8
      eight_bit_clock_sel_low <= serial_timer_control[EIGHT_LOW_BIT]; // R8
    end
  end
endmodule
